/* File: logic/ofm_oscillator_supervisor.sv */
`timescale 1ns/1ps

// How it works
// - Failing main oscillator means chip clock from RC.
// - Chip held in reset while failure persists.
// - After recovery, hold reset another 0.25 ms.
// - Failure whenever RC outruns main, even unstarted.
// - Power-down exit supervised like normal monitoring.
// - Power-on reset logic clocked from RC output.
// - Port pins driven to reset state meanwhile.
// - Reset state reached within 18 us typical.
// - Enable low disables RC, unit has no effect.
module ofm_oscillator_supervisor
#(
    // Stabilisation length in system cycles; shorten for simulation.
    parameter int STAB_CYCLES = ofm_pkg::STAB_CYCLES
)
(
    input wire logic i_sys_clk,
    input wire logic i_rstn,
    input wire logic i_osc_monitor_enable_pin,
    input wire logic i_main_osc,
    input wire logic i_rc_osc,
    input wire logic i_hw_powerdown,
    output logic o_rc_enable,
    output ofm_pkg::ofm_ctrl_s o_ctrl,
    output logic o_reset_valid
);

    // Synchronised enable pin level.
    logic enable_lvl;

    // Rising edges of the two oscillators, one cycle each.
    logic main_rise;
    logic rc_rise;

    // Synchronised power-down request.
    logic powerdown_lvl;

    // Supervision state and its next value.
    ofm_pkg::ofm_state_e state_reg;
    ofm_pkg::ofm_state_e state_next;

    // Reference periods seen in the current window.
    logic [ofm_pkg::WIN_CNT_W-1:0] ref_cnt_reg;

    // Main oscillator edges seen in the current window, saturating.
    logic [ofm_pkg::WIN_CNT_W-1:0] main_cnt_reg;

    // Window closes on this reference edge.
    logic window_done;

    // Window verdict: too few main edges.
    logic window_fail;

    // Stabilisation cycles elapsed.
    logic [ofm_pkg::STAB_CNT_W-1:0] stab_cnt_reg;

    // Cycles spent holding the chip in RC-clocked reset.
    logic [ofm_pkg::POR_CNT_W-1:0] por_cnt_reg;

    // Registered controls toward the chip.
    ofm_pkg::ofm_ctrl_s ctrl_reg;

    // Registered reset-state indicator.
    logic reset_valid_reg;

    // Edges counted after reset until the enable level is trusted.
    logic [2:0] settle_cnt_reg;

    // Last stabilisation count, cut to the counter width.
    localparam logic [ofm_pkg::STAB_CNT_W-1:0] STAB_LAST =
        ofm_pkg::STAB_CNT_W'(STAB_CYCLES - 1);

    // Last reference count of a window.
    localparam logic [ofm_pkg::WIN_CNT_W-1:0] REF_LAST =
        ofm_pkg::WIN_CNT_W'(ofm_pkg::REF_WINDOW - 1);

    // Power-on count at which the reset state counts as reached.
    localparam logic [ofm_pkg::POR_CNT_W-1:0] POR_LAST =
        ofm_pkg::POR_CNT_W'(ofm_pkg::POR_TYP_CYCLES - 1);

    // The pin, both oscillators and power-down come from other domains.
    ofm_pin_sync u_sync_enable
    (
        .i_sys_clk (i_sys_clk),
        .i_rstn (i_rstn),
        .i_async (i_osc_monitor_enable_pin),
        .o_level (enable_lvl),
        .o_rise ()
    );

    ofm_pin_sync u_sync_main
    (
        .i_sys_clk (i_sys_clk),
        .i_rstn (i_rstn),
        .i_async (i_main_osc),
        .o_level (),
        .o_rise (main_rise)
    );

    ofm_pin_sync u_sync_rc
    (
        .i_sys_clk (i_sys_clk),
        .i_rstn (i_rstn),
        .i_async (i_rc_osc),
        .o_level (),
        .o_rise (rc_rise)
    );

    ofm_pin_sync u_sync_pd
    (
        .i_sys_clk (i_sys_clk),
        .i_rstn (i_rstn),
        .i_async (i_hw_powerdown),
        .o_level (powerdown_lvl),
        .o_rise ()
    );

    // The window closes on the last reference edge of the window.
    assign window_done = rc_rise && (ref_cnt_reg == REF_LAST);

    // A main oscillator that has not started counts zero and fails.
    assign window_fail = main_cnt_reg < ofm_pkg::MAIN_MIN_EDGES;

    // Reference window counter; restarts when disabled or powered down.
    always_ff @(posedge i_sys_clk)
    begin
        if (!i_rstn)
        begin
            ref_cnt_reg <= ofm_pkg::WIN_CNT_RESET;
        end
        else if (!enable_lvl || powerdown_lvl)
        begin
            ref_cnt_reg <= ofm_pkg::WIN_CNT_RESET;
        end
        else if (window_done)
        begin
            ref_cnt_reg <= ofm_pkg::WIN_CNT_RESET;
        end
        else if (rc_rise)
        begin
            ref_cnt_reg <= ref_cnt_reg + 8'h01;
        end
    end

    // Main edge counter; saturates so a fast crystal never wraps.
    always_ff @(posedge i_sys_clk)
    begin
        if (!i_rstn)
        begin
            main_cnt_reg <= ofm_pkg::WIN_CNT_RESET;
        end
        else if (!enable_lvl || powerdown_lvl || window_done)
        begin
            // An edge landing on the closing cycle is dropped; the
            // threshold equals REF_WINDOW, so it leaves no margin for that loss.
            main_cnt_reg <= ofm_pkg::WIN_CNT_RESET;
        end
        else if (main_rise && (main_cnt_reg != 8'hff))
        begin
            main_cnt_reg <= main_cnt_reg + 8'h01;
        end
    end

    // Next supervision state.
    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            ofm_pkg::OFM_FAIL:
            begin
                // Leave failure only on a healthy window.
                if (window_done && !window_fail)
                begin
                    state_next = ofm_pkg::OFM_STAB;
                end
            end
            ofm_pkg::OFM_STAB:
            begin
                if (window_done && window_fail)
                begin
                    state_next = ofm_pkg::OFM_FAIL;
                end
                else if (stab_cnt_reg == STAB_LAST)
                begin
                    state_next = ofm_pkg::OFM_RUN;
                end
            end
            ofm_pkg::OFM_RUN:
            begin
                if (window_done && window_fail)
                begin
                    state_next = ofm_pkg::OFM_FAIL;
                end
            end
        endcase
    end

    // State register; power-down and disable restart supervision.
    always_ff @(posedge i_sys_clk)
    begin
        if (!i_rstn)
        begin
            state_reg <= ofm_pkg::OFM_FAIL;
        end
        else if (!enable_lvl || powerdown_lvl)
        begin
            // Power-down exit then runs the same path as a failure.
            state_reg <= ofm_pkg::OFM_FAIL;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // Stabilisation counter runs only in the final reset phase.
    always_ff @(posedge i_sys_clk)
    begin
        if (!i_rstn)
        begin
            stab_cnt_reg <= '0;
        end
        else if (state_reg != ofm_pkg::OFM_STAB || state_next !=
                 ofm_pkg::OFM_STAB || !enable_lvl || powerdown_lvl)
        begin
            stab_cnt_reg <= '0;
        end
        else
        begin
            stab_cnt_reg <= stab_cnt_reg + 20'h00001;
        end
    end

    // Counts RC-clocked reset cycles until the reset state is settled.
    always_ff @(posedge i_sys_clk)
    begin
        if (!i_rstn)
        begin
            por_cnt_reg <= '0;
            reset_valid_reg <= 1'b0;
        end
        else if (!enable_lvl)
        begin
            por_cnt_reg <= '0;
            reset_valid_reg <= 1'b0;
        end
        else if (por_cnt_reg != POR_LAST)
        begin
            por_cnt_reg <= por_cnt_reg + 11'h001;
        end
        else
        begin
            reset_valid_reg <= 1'b1;
        end
    end

    // Controls toward the chip; all inert while the unit is disabled.
    always_ff @(posedge i_sys_clk)
    begin
        if (!i_rstn)
        begin
            ctrl_reg <= ofm_pkg::CTRL_RESET;
            settle_cnt_reg <= '0;
        end
        else if (settle_cnt_reg != ofm_pkg::SYNC_SETTLE)
        begin
            // Enable level still unknown, so the chip is not let go.
            settle_cnt_reg <= settle_cnt_reg + 3'h1;
            ctrl_reg <= ofm_pkg::CTRL_RESET;
        end
        else if (!enable_lvl)
        begin
            ctrl_reg <= '0;
        end
        else if (powerdown_lvl)
        begin
            ctrl_reg <= ofm_pkg::CTRL_RESET;
        end
        else
        begin
            // RC clock only while the main oscillator is judged failed.
            ctrl_reg.clk_sel_rc <= (state_next == ofm_pkg::OFM_FAIL);
            ctrl_reg.chip_reset <= (state_next != ofm_pkg::OFM_RUN);
            ctrl_reg.port_reset <= (state_next != ofm_pkg::OFM_RUN);
        end
    end

    // The RC reference runs only while the pin enables the unit.
    assign o_rc_enable = enable_lvl;
    assign o_ctrl = ctrl_reg;
    assign o_reset_valid = reset_valid_reg;

endmodule // ofm_oscillator_supervisor

/* File: include/ofm_pkg.sv */
package ofm_pkg;

    // System clock period in nanoseconds.
    localparam int CLK_PERIOD_NS = 10;

    // Final stabilisation phase after the main oscillator recovers.
    localparam int STAB_TIME_NS = 250000;

    // A least time, so the count rounds up to whole cycles.
    localparam int STAB_CYCLES =
        (STAB_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Typical delay from power-on to a correct reset state.
    localparam int POR_TYP_NS = 18000;

    // A longest time, so the count rounds down.
    localparam int POR_TYP_CYCLES = POR_TYP_NS / CLK_PERIOD_NS;

    // Width of the power-on counter, wide enough for POR_TYP_CYCLES.
    localparam int POR_CNT_W = 11;

    // Width of the stabilisation counter, wide enough for the default.
    localparam int STAB_CNT_W = 20;

    // Reference periods that make one comparison window.
    localparam int REF_WINDOW = 16;

    // Width of the window counters.
    localparam int WIN_CNT_W = 8;

    // Least main-oscillator edges per window for a healthy oscillator.
    localparam logic [WIN_CNT_W-1:0] MAIN_MIN_EDGES = 8'h10;

    // Value of the window counters after reset.
    localparam logic [WIN_CNT_W-1:0] WIN_CNT_RESET = 8'h00;

    // Edges after reset before the enable synchroniser gives a verdict.
    localparam logic [2:0] SYNC_SETTLE = 3'h4;

    // Supervision states.
    typedef enum logic [1:0] {
        OFM_FAIL,
        OFM_STAB,
        OFM_RUN
    } ofm_state_e;

    // Clock and reset controls handed to the chip.
    typedef struct packed {
        logic clk_sel_rc;
        logic chip_reset;
        logic port_reset;
    } ofm_ctrl_s;

    // Controls after reset: RC clock selected and the chip held in reset.
    localparam ofm_ctrl_s CTRL_RESET = 3'h7;

endpackage

/* File: logic/ofm_pin_sync.sv */
`timescale 1ns/1ps

// Brings one foreign level into the system clock domain.
// A change is accepted only once the second and third stages agree.
module ofm_pin_sync
(
    input wire logic i_sys_clk,
    input wire logic i_rstn,
    input wire logic i_async,
    output logic o_level,
    output logic o_rise
);

    // Three-stage shift chain; stage 0 is read only by stage 1.
    logic [2:0] chain_reg;

    // Accepted, debounced level.
    logic level_reg;

    // One-cycle pulse on an accepted rising change.
    logic rise_reg;

    // Shift the foreign level through the chain.
    always_ff @(posedge i_sys_clk)
    begin
        if (!i_rstn)
        begin
            chain_reg <= 3'h0;
        end
        else
        begin
            chain_reg <= {chain_reg[1:0], i_async};
        end
    end

    // Accept a new level only when the two later stages agree.
    always_ff @(posedge i_sys_clk)
    begin
        if (!i_rstn)
        begin
            level_reg <= 1'b0;
            rise_reg <= 1'b0;
        end
        else if (chain_reg[1] == chain_reg[2])
        begin
            level_reg <= chain_reg[2];
            rise_reg <= chain_reg[2] & ~level_reg;
        end
        else
        begin
            // Stages disagree, so the old level is kept.
            rise_reg <= 1'b0;
        end
    end

    assign o_level = level_reg;
    assign o_rise = rise_reg;

endmodule // ofm_pin_sync

/* File: test/ofm_sup_sva.sv */
`timescale 1ns/1ps

// Watches the supervisor pins for clock and reset sequencing slips.
module ofm_sup_sva
#(
    parameter int STAB_CYCLES = 20
)
(
    input wire logic i_sys_clk,
    input wire logic i_rstn,
    input wire logic i_osc_monitor_enable_pin,
    input wire logic i_main_osc,
    input wire logic i_rc_osc,
    input wire logic i_hw_powerdown,
    input wire logic o_rc_enable,
    input wire ofm_pkg::ofm_ctrl_s o_ctrl,
    input wire logic o_reset_valid
);

    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_rstn);

    logic [15:0] stab_cnt; // Cycles spent in the hold phase.
    logic [11:0] por_cnt; // Enabled cycles, saturating.
    logic [11:0] idle_cnt; // Cycles since the main clock last moved.
    logic main_q; // Main clock one cycle ago.

    // Measures the stabilisation hold in whole cycles.
    always_ff @(posedge i_sys_clk)
    begin
        if (!i_rstn || o_ctrl != 3'h3)
            stab_cnt <= '0;
        else
            stab_cnt <= stab_cnt + 16'h1;
    end

    // Measures time since the unit came alive; saturates, never wraps.
    always_ff @(posedge i_sys_clk)
    begin
        if (!i_rstn || !o_rc_enable)
            por_cnt <= '0;
        else if (!(&por_cnt))
            por_cnt <= por_cnt + 12'h1;
    end

    // Measures how long the main clock has stood still.
    always_ff @(posedge i_sys_clk)
    begin
        main_q <= i_main_osc;
        if (!i_rstn || main_q != i_main_osc)
            idle_cnt <= '0;
        else if (!(&idle_cnt))
            idle_cnt <= idle_cnt + 12'h1;
    end

    power_on_hold_a:
        assert property ($rose(i_rstn) |-> (o_ctrl == 3'h7) [*4])
        else $error("chip left reset before enable was known");
    port_follows_a:
        assert property (o_ctrl.port_reset == o_ctrl.chip_reset)
        else $error("port reset differs from chip reset");
    rc_holds_reset_a:
        assert property (o_ctrl.clk_sel_rc |-> o_ctrl.chip_reset)
        else $error("RC clock chosen without chip reset");
    off_no_effect_a:
        assert property (!i_osc_monitor_enable_pin [*6]
            |-> o_ctrl == 3'h0 && !o_rc_enable)
        else $error("disabled unit still acts");
    on_rc_runs_a:
        assert property (i_osc_monitor_enable_pin [*6] |-> o_rc_enable)
        else $error("RC not enabled");
    pd_forces_a:
        assert property ((i_osc_monitor_enable_pin && i_hw_powerdown) [*6]
            |-> o_ctrl == 3'h7)
        else $error("power-down not held in reset");
    stab_length_a:
        assert property ($fell(o_ctrl.chip_reset) && i_osc_monitor_enable_pin
            |-> stab_cnt == 16'(STAB_CYCLES))
        else $error("hold phase has wrong length");
    por_time_a:
        assert property ($rose(o_reset_valid)
            |-> por_cnt >= 12'h6a4 && por_cnt <= 12'hd48)
        else $error("reset state not settled in time");
    stall_fails_a:
        assert property (idle_cnt > 12'h3e8 && o_rc_enable
            |-> o_ctrl.clk_sel_rc)
        else $error("silent main clock not caught");

endmodule // ofm_sup_sva

bind ofm_oscillator_supervisor ofm_sup_sva #(.STAB_CYCLES(STAB_CYCLES))
    i_sva (.i_sys_clk, .i_rstn, .i_osc_monitor_enable_pin, .i_main_osc,
    .i_rc_osc, .i_hw_powerdown, .o_rc_enable, .o_ctrl, .o_reset_valid);

/* File: test/ofm_osc_model.sv */
`timescale 1ns/1ps

// Behavioural main oscillator and RC reference oscillator.
module ofm_osc_model
(
    input wire logic [1:0] i_mode,
    input wire logic i_rc_on,
    output logic o_main,
    output logic o_rc
);

    // RC reference at 5 MHz; switched off it parks low.
    initial
    begin
        o_rc = 1'b0;
        forever
        begin
            #100;
            o_rc = i_rc_on ? ~o_rc : 1'b0;
        end
    end

    // Main clock: 0 silent, 1 slower, 2 faster than the reference.
    // A dead crystal keeps its last level, so silent means frozen.
    initial
    begin
        o_main = 1'b0;
        forever
        begin
            #(i_mode == 2'h2 ? 40 : 300);
            if (i_mode != 2'h0)
                o_main = ~o_main;
        end
    end

endmodule // ofm_osc_model

/* File: test/testbench.sv */
`timescale 1ns/1ps

// Walks the supervisor through power-on, recovery, failure,
// power-down and disable, judging its clock and reset controls.
module testbench;

    localparam int STAB = 20; // Short hold keeps the run brief.

    logic i_sys_clk = 1'b0;
    logic i_rstn = 1'b0;
    logic i_osc_monitor_enable_pin = 1'b1; // Held high to use it.
    logic i_hw_powerdown = 1'b0;
    logic [1:0] main_mode = 2'h0; // Main clock: off, slow, fast.
    logic i_main_osc;
    logic i_rc_osc;
    logic o_rc_enable;
    ofm_pkg::ofm_ctrl_s o_ctrl;
    logic o_reset_valid;
    int n_fail = 0;
    int cmp_count = 0;
    int cyc = 0;

    // Free running 100 MHz system clock.
    initial
    begin
        forever #5 i_sys_clk = ~i_sys_clk;
    end

    ofm_oscillator_supervisor #(.STAB_CYCLES(STAB)) i_dut (
        .i_sys_clk, .i_rstn, .i_osc_monitor_enable_pin, .i_main_osc,
        .i_rc_osc, .i_hw_powerdown, .o_rc_enable, .o_ctrl, .o_reset_valid);

    ofm_osc_model i_osc (.i_mode(main_mode), .i_rc_on(o_rc_enable),
        .o_main(i_main_osc), .o_rc(i_rc_osc));

    // Prints the verdict and ends the run.
    task automatic stop_test();
        if (n_fail == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // Compares one observed value with its expectation.
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            n_fail++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    // Waits on falling edges, bounded, for the controls to settle.
    task automatic wait_ctrl(input logic [2:0] exp, input int lim);
        repeat (lim)
            if (o_ctrl !== exp)
                @(negedge i_sys_clk);
    endtask

    // Power-on with the main clock silent: reset held from the RC.
    task automatic t_power_on();
        check(o_ctrl, 3'h7);
        repeat (2) @(negedge i_sys_clk);
        check(o_ctrl, 3'h7);
        repeat (6) @(negedge i_sys_clk);
        check(o_rc_enable, 1'b1);
        repeat (3400)
            if (o_reset_valid !== 1'b1)
                @(negedge i_sys_clk);
        check(o_reset_valid, 1'b1);
        check(o_ctrl, 3'h7);
    endtask

    // Main clock starts: clock moves to it, reset held, then released.
    task automatic t_recover();
        int n = 0;
        main_mode = 2'h2;
        wait_ctrl(3'h3, 1000);
        check(o_ctrl, 3'h3);
        while (o_ctrl === 3'h3 && n < 1000)
        begin
            @(negedge i_sys_clk);
            n++;
        end
        check(n[15:0], 16'(STAB));
        check(o_ctrl, 3'h0);
    endtask

    // Main clock falls below the reference: back to RC and reset.
    task automatic t_fail();
        main_mode = 2'h1;
        wait_ctrl(3'h7, 1000);
        check(o_ctrl, 3'h7);
    endtask

    // Power-down from run, then a supervised restart.
    task automatic t_powerdown();
        t_recover();
        i_hw_powerdown = 1'b1;
        repeat (5) @(negedge i_sys_clk);
        check(o_ctrl, 3'h7);
        main_mode = 2'h0;
        repeat (700) @(negedge i_sys_clk);
        i_hw_powerdown = 1'b0;
        repeat (200) @(negedge i_sys_clk);
        check(o_ctrl, 3'h7);
        t_recover();
    endtask

    // Enable low: no effect even with a failing main clock.
    task automatic t_disable();
        main_mode = 2'h1;
        i_osc_monitor_enable_pin = 1'b0;
        repeat (8) @(negedge i_sys_clk);
        check(o_ctrl, 3'h0);
        check(o_rc_enable, 1'b0);
        repeat (700) @(negedge i_sys_clk);
        check(o_ctrl, 3'h0);
        i_osc_monitor_enable_pin = 1'b1;
        repeat (8) @(negedge i_sys_clk);
        check(o_ctrl, 3'h7);
    endtask

    // Main sequence; reset held for 16 cycles first.
    initial
    begin
        repeat (16) @(negedge i_sys_clk);
        i_rstn = 1'b1;
        t_power_on();
        t_recover();
        t_fail();
        t_powerdown();
        t_disable();
        stop_test();
    end

    // Cuts a hung run short; the tests need about 5000 cycles.
    always @(posedge i_sys_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_fail++;
            stop_test();
        end
    end

endmodule // testbench
